// >>> shared/gcs_pkg.sv
// ************************************************************
// constants for the glitchless clock switch
// ************************************************************
package gcs_pkg;

   // system clock period, picoseconds
   localparam int CLK_PERIOD_PS        = 10000;

   // axi4-lite address width and word offsets
   localparam int          AXI_ADDR_W  = 4;
   localparam logic [3:0]  CTRL_OFS    = 4'h0;
   localparam logic [3:0]  GATE_OFS    = 4'h4;
   localparam logic [3:0]  STAT_OFS    = 4'h8;

   // control register fields
   localparam int          CTRL_SEL_BIT   = 0;
   localparam int          CTRL_FORCE_BIT = 1;
   localparam int          CTRL_DLVL_BIT  = 2;
   localparam int          CTRL_SLEEP_BIT = 3;
   localparam logic [3:0]  CTRL_RESET     = 4'h8;
   localparam logic [31:0] GATE_RESET     = 32'h0000_0000;

   // status register fields
   localparam int          STAT_SRC_BIT   = 0;
   localparam int          STAT_DRAIN_BIT = 1;
   localparam int          STAT_PARK_BIT  = 2;
   localparam int          STAT_SLEEP_BIT = 3;

   // axi response codes
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // falling edges of the new clock seen while parked before restart
   localparam logic [1:0]  PARK_FALLS  = 2'h2;

   // gate disable time, longest, rounded down, at least one cycle
   localparam int GATE_DIS_TIME_PS     = 3500;
   localparam int GATE_DIS_CYCLES      = (GATE_DIS_TIME_PS / CLK_PERIOD_PS) < 1 ? 1
                                         : GATE_DIS_TIME_PS / CLK_PERIOD_PS;

   // sleep entry time, longest, rounded down
   localparam int SLEEP_ENTRY_TIME_US  = 100;
   localparam int SLEEP_ENTRY_CYCLES   = (SLEEP_ENTRY_TIME_US * 1000000) / CLK_PERIOD_PS;

   // switch states
   typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_PARK} gcs_state_t;

endpackage : gcs_pkg

// >>> rtl/gcs_sync3.sv
// ************************************************************
// three-stage pin synchroniser with agreement filter
// ************************************************************
module gcs_sync3
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_in,
   output logic      level_out
);

   logic stage1_q;   // metastable stage, read only by stage2
   logic stage2_q;   // second stage
   logic stage3_q;   // third stage

   // shift chain; the level updates once stages two and three agree
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stage1_q  <= 1'b0;
         stage2_q  <= 1'b0;
         stage3_q  <= 1'b0;
         level_out <= 1'b0;
      end
      else
      begin
         stage1_q <= pin_in;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         if (stage2_q == stage3_q)
            level_out <= stage3_q;
      end
   end

endmodule : gcs_sync3

// >>> rtl/gcs_switch.sv
// Operation
// - park output low at next falling edge
// - stay parked at most three new cycles
// - restart on a rising edge of new clock
// - dead selected clock leaves output undefined
// - force rising parks output low at once
// - held force ignores deselected clock and select
// - sleep drives both output legs high
// - sleep reached within one hundred microseconds
// - gated output takes disabled level quickly
// - sleep_n low requests sleep
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module gcs_switch
   import gcs_pkg::*;
#(
   parameter int NUM_OUT            = 16,
   parameter int SLEEP_ENTRY_LIMIT  = SLEEP_ENTRY_CYCLES
)
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  clk_primary,
   input  wire logic                  clk_secondary,
   output logic [NUM_OUT-1:0]         clock_out,
   output logic [NUM_OUT-1:0]         clock_out_n,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output logic [1:0]                 s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp
);

   localparam int GateLat = GATE_DIS_CYCLES;

   // ************************************************************
   // helper functions
   // ************************************************************

   // word offset match on an aligned address
   function automatic logic word_hit(input logic [AXI_ADDR_W-1:0] addr,
                                     input logic [3:0] ofs);
      word_hit = (addr[AXI_ADDR_W-1:2] == ofs[3:2]);
   endfunction : word_hit

   // merge write data into a register under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      merge = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            merge[i*8 +: 8] = data[i*8 +: 8];
   endfunction : merge

   // ************************************************************
   // registers and bus slave state
   // ************************************************************
   logic [3:0]            ctrl_q;       // select, force, disabled level, sleep_n
   logic [NUM_OUT-1:0]    gate_q;       // output_gate_n, high disables an output
   logic                  aw_held_q;    // write address captured
   logic [AXI_ADDR_W-1:0] awaddr_q;     // captured write address
   logic                  w_held_q;     // write data captured
   logic [31:0]           wdata_q;      // captured write data
   logic [3:0]            wstrb_q;      // captured byte strobes
   logic                  bvalid_q;     // write response pending
   logic [1:0]            bresp_q;      // write response code
   logic                  rvalid_q;     // read data pending
   logic [31:0]           rdata_q;      // read data
   logic [1:0]            rresp_q;      // read response code

   wire        wr_fire  = aw_held_q && w_held_q && !bvalid_q;
   wire        wr_ctrl  = wr_fire && word_hit(awaddr_q, CTRL_OFS);
   wire        wr_gate  = wr_fire && word_hit(awaddr_q, GATE_OFS);
   wire        wr_ok    = wr_ctrl || wr_gate || word_hit(awaddr_q, STAT_OFS);
   wire        rd_fire  = s_axi_arvalid && !rvalid_q;
   wire        rd_ok    = word_hit(s_axi_araddr, CTRL_OFS) || word_hit(s_axi_araddr, GATE_OFS)
                          || word_hit(s_axi_araddr, STAT_OFS);
   wire [31:0] wr_merge = merge(word_hit(awaddr_q, CTRL_OFS) ? {28'h0, ctrl_q}
                                : 32'(gate_q), wdata_q, wstrb_q);

   // handshake outputs
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // capture address and data in either order, answer once both are in
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         // response: unmapped addresses answer slverr
         if (wr_fire)
         begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   // software-written control and gate registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= CTRL_RESET;
         gate_q <= GATE_RESET[NUM_OUT-1:0];
      end
      else if (wr_ctrl)
         ctrl_q <= wr_merge[3:0];
      else if (wr_gate)
         gate_q <= wr_merge[NUM_OUT-1:0];
   end

   // ************************************************************
   // input clock sampling and control resynchronisation
   // ************************************************************
   logic       lvl_a;         // primary clock level, filtered
   logic       lvl_b;         // secondary clock level, filtered
   logic       lvl_a_prev_q;  // previous primary level
   logic       lvl_b_prev_q;  // previous secondary level
   logic [1:0] sel_sync_q;    // select resynchroniser
   logic [1:0] frc_sync_q;    // force resynchroniser
   logic       frc_prev_q;    // force level last cycle

   gcs_sync3 u_sync_a
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_in    (clk_primary),
      .level_out (lvl_a)
   );

   gcs_sync3 u_sync_b
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_in    (clk_secondary),
      .level_out (lvl_b)
   );

   // two-flop staging of select and force
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sel_sync_q   <= 2'h0;
         frc_sync_q   <= 2'h0;
         frc_prev_q   <= 1'b0;
         lvl_a_prev_q <= 1'b0;
         lvl_b_prev_q <= 1'b0;
      end
      else
      begin
         sel_sync_q   <= {sel_sync_q[0], ctrl_q[CTRL_SEL_BIT]};
         frc_sync_q   <= {frc_sync_q[0], ctrl_q[CTRL_FORCE_BIT]};
         frc_prev_q   <= frc_sync_q[1];
         lvl_a_prev_q <= lvl_a;
         lvl_b_prev_q <= lvl_b;
      end
   end

   // ************************************************************
   // switch state machine
   // ************************************************************
   gcs_state_t st_q;        // switch state
   gcs_state_t st_d;
   logic       cur_sel_q;   // active source, 1 = secondary
   logic       cur_sel_d;
   logic [1:0] falls_q;     // new-clock falling edges while parked
   logic [1:0] falls_d;
   logic       clk_q;       // switched clock before output gating
   logic       clk_d;

   wire sel_s    = sel_sync_q[1];
   wire frc_s    = frc_sync_q[1];
   wire frc_rise = frc_s && !frc_prev_q;
   // only the active source is ever looked at
   wire cur_lvl  = cur_sel_q ? lvl_b : lvl_a;
   wire cur_prev = cur_sel_q ? lvl_b_prev_q : lvl_a_prev_q;
   wire cur_rise = cur_lvl && !cur_prev;
   wire cur_fall = !cur_lvl && cur_prev;

   // next-state logic; a dead active clock leaves clk_q wherever it was
   always_comb
   begin
      st_d      = st_q;
      cur_sel_d = cur_sel_q;
      falls_d   = falls_q;
      clk_d     = clk_q;
      // force rising parks low at once and retargets to select
      if (frc_rise)
      begin
         st_d      = ST_PARK;
         cur_sel_d = sel_s;
         falls_d   = 2'h0;
         clk_d     = 1'b0;
      end
      else
      begin
         unique case (st_q)
            ST_RUN:
            begin
               clk_d = cur_lvl;
               // select changes are ignored while force is held
               if (!frc_s && sel_s != cur_sel_q)
                  st_d = ST_DRAIN;
            end
            ST_DRAIN:
            begin
               // keep following the old clock until it falls
               if (!clk_q)
               begin
                  st_d      = ST_PARK;
                  cur_sel_d = sel_s;
                  falls_d   = 2'h0;
               end
               else
                  clk_d = cur_lvl;
            end
            ST_PARK:
            begin
               // count falling edges of the new clock while low
               clk_d = 1'b0;
               if (cur_fall && falls_q != PARK_FALLS)
                  falls_d = falls_q + 2'h1;
               // restart exactly on a rising edge
               if (falls_q == PARK_FALLS && cur_rise)
               begin
                  st_d  = ST_RUN;
                  clk_d = 1'b1;
               end
            end
         endcase
      end
   end

   // state registers; no output value is assumed for a dead clock
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q      <= ST_PARK;
         cur_sel_q <= 1'b0;
         falls_q   <= 2'h0;
         clk_q     <= 1'b0;
      end
      else
      begin
         st_q      <= st_d;
         cur_sel_q <= cur_sel_d;
         falls_q   <= falls_d;
         clk_q     <= clk_d;
      end
   end

   // ************************************************************
   // output legs, gating and sleep
   // ************************************************************
   wire                sleep_n   = ctrl_q[CTRL_SLEEP_BIT];
   wire                dis_level = ctrl_q[CTRL_DLVL_BIT];
   // gated outputs take the disabled level
   wire [NUM_OUT-1:0]  leg_true  = (~gate_q & {NUM_OUT{clk_q}}) | (gate_q & {NUM_OUT{dis_level}});
   wire [NUM_OUT-1:0]  true_d    = sleep_n ? leg_true : {NUM_OUT{1'b1}};
   wire [NUM_OUT-1:0]  comp_d    = sleep_n ? ~leg_true : {NUM_OUT{1'b1}};

   // registered legs; sleep_n low means power-down
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clock_out   <= '0;
         clock_out_n <= '1;
      end
      else
      begin
         clock_out   <= true_d;
         clock_out_n <= comp_d;
      end
   end

   // read data and status
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         if (word_hit(s_axi_araddr, CTRL_OFS))
            rdata_q <= {28'h0, ctrl_q};
         else if (word_hit(s_axi_araddr, GATE_OFS))
            rdata_q <= 32'(gate_q);
         else if (word_hit(s_axi_araddr, STAT_OFS))
            rdata_q <= {28'h0, !sleep_n, st_q == ST_PARK, st_q == ST_DRAIN, cur_sel_q};
         else
            rdata_q <= 32'h0000_0000;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [31:0] sleep_wait_q;   // cycles spent asleep without both legs high
   always_ff @(posedge aclk)
   begin
      if (!aresetn || sleep_n || (&clock_out && &clock_out_n))
         sleep_wait_q <= 32'h0000_0000;
      else
         sleep_wait_q <= sleep_wait_q + 32'h0000_0001;
   end

   a_drain_falls_low: assert property (
      (st_q == ST_DRAIN && clk_q && cur_fall && !frc_rise) |=> !clk_q ##1 st_q == ST_PARK)
      else $error("drain did not park low on the old falling edge");
   a_park_stays_low: assert property (
      st_q == ST_PARK |-> !clk_q && falls_q <= PARK_FALLS)
      else $error("output not low while parked");
   a_restart_rises: assert property (
      (st_q == ST_PARK && falls_q == PARK_FALLS && cur_rise && !frc_rise)
      |=> st_q == ST_RUN && clk_q && $past(cur_lvl))
      else $error("restart not on a rising edge of the new clock");
   a_force_parks: assert property (
      frc_rise |=> st_q == ST_PARK && !clk_q && cur_sel_q == $past(sel_s))
      else $error("force rising did not park low on selected input");
   a_force_isolates: assert property (
      (frc_s && !frc_rise && st_q == ST_RUN) |=> $stable(cur_sel_q) && st_q != ST_DRAIN)
      else $error("active source moved while force held");
   a_sleep_legs_high: assert property (
      !sleep_n |=> &clock_out && &clock_out_n)
      else $error("sleep did not pull both legs high");
   a_sleep_entry_time: assert property (
      sleep_wait_q < 32'(SLEEP_ENTRY_LIMIT))
      else $error("sleep entry exceeded its limit");
   a_gate_level: assert property (
      (sleep_n && gate_q[0]) |-> ##[1:GateLat] clock_out[0] == $past(dis_level)
      && clock_out_n[0] == !$past(dis_level))
      else $error("gated output not at disabled level");
   a_sel_two_stage: assert property (
      (st_q == ST_DRAIN && !clk_q && !frc_rise) |=> cur_sel_q == $past(sel_sync_q[1]))
      else $error("source taken from unsynchronised select");

endmodule : gcs_switch

// >>> dv/gcs_clk_src.sv
// ************************************************************
// input clock source model
// ************************************************************
module gcs_clk_src
#(
   parameter int HALF_NS = 100
)
(
   input  wire logic run,
   output logic      clk_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // source swings only while run is high
   // toggles while running, a dead source sits at dc low
   initial
   begin
      clk_o = 1'b0;
      forever
      begin
         #(HALF_NS);
         clk_o = run ? ~clk_o : 1'b0;
      end
   end
endmodule : gcs_clk_src

// >>> dv/gcs_switch_tb.sv
// ************************************************************
// self-checking bench for the clock switch
// ************************************************************
module gcs_switch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gcs_pkg::*;

   // run limits in aclk cycles: primary half 10, secondary half 16
   localparam int MIN_RUN = 8;
   localparam int MAX_HI  = 20;
   localparam int MAX_LO  = 108;

   logic        aclk, aresetn, run_p, run_s, clk_p, clk_s;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, mon_on, prev;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, ctrl_m, gate_m, got;
   logic [1:0]  bresp, rresp, rsp;
   logic [15:0] q, q_n;
   int          error_cnt, samples_checked, seed, cyc, run_len, edges, e0;

   // far-side clock sources
   gcs_clk_src #(.HALF_NS(100)) i_src_p (.run(run_p), .clk_o(clk_p));
   gcs_clk_src #(.HALF_NS(160)) i_src_s (.run(run_s), .clk_o(clk_s));

   gcs_switch #(.NUM_OUT(16), .SLEEP_ENTRY_LIMIT(8)) i_gcs_switch
   (
      .aclk(aclk), .aresetn(aresetn), .clk_primary(clk_p), .clk_secondary(clk_s),
      .clock_out(q), .clock_out_n(q_n),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp)
   );

   // ************************************************************
   // clock, timeout and checking
   // ************************************************************
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // cut a hang short
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end

   task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chk_reg

   task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
      chk_reg({30'h0, e}, {30'h0, g});
   endtask : chk_resp

   task automatic chk_leg(input logic [15:0] e, input logic [15:0] g);
      chk_reg({16'h0, e}, {16'h0, g});
   endtask : chk_leg

   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   // pulse-width monitor on output 0, sampled mid-cycle
   always @(negedge aclk)
   begin
      if (!mon_on)
         run_len = -1;
      else if (q[0] !== prev)
      begin
         if (run_len >= 0)
            chk_reg(32'h1, {31'h0, run_len >= MIN_RUN && run_len <= (prev ? MAX_HI : MAX_LO)});
         chk_leg(~q, q_n);
         run_len = 1;
         edges++;
      end
      else if (run_len >= 0)
         run_len++;
      prev = q[0];
   end

   // ************************************************************
   // bus tasks and register model
   // ************************************************************
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_hs, w_hs, b_hs;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      bready  <= 1'b1;
      b_hs = 1'b0;
      while (!b_hs)
      begin
         @(negedge aclk);
         aw_hs = awvalid & awready;
         w_hs  = wvalid & wready;
         b_hs  = bvalid & bready;
         r     = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) bready <= 1'b0;
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hs, r_hs;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      r_hs = 1'b0;
      while (!r_hs)
      begin
         @(negedge aclk);
         ar_hs = arvalid & arready;
         r_hs  = rvalid & rready;
         d     = rdata;
         r     = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
         if (r_hs) rready <= 1'b0;
      end
   endtask : axi_rd

   // write and update the model; unmapped offsets answer an error
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      axi_wr(a, d, rsp);
      chk_resp((a == 4'hC) ? RESP_SLVERR : RESP_OKAY, rsp);
      if (a == CTRL_OFS) ctrl_m = d & 32'hF;
      if (a == GATE_OFS) gate_m = d & 32'hFFFF;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      axi_rd(a, got, rsp);
      chk_reg(e, got);
      chk_resp((a == 4'hC) ? RESP_SLVERR : RESP_OKAY, rsp);
   endtask : rd

   // let the output run, then expect toggling and the status word
   task automatic settle(input logic [31:0] st);
      e0 = edges;
      repeat (600) @(posedge aclk);
      chk_reg(32'h1, {31'h0, edges > e0 + 10});
      rd(STAT_OFS, st);
   endtask : settle

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      seed = 11;
      {error_cnt, samples_checked, cyc, edges, run_len} = '0;
      {aresetn, awvalid, wvalid, bready, arvalid, rready, mon_on, prev} = '0;
      {awaddr, araddr, wdata} = '0;
      run_p  = 1'b1;
      run_s  = 1'b1;
      ctrl_m = {28'h0, CTRL_RESET};
      gate_m = GATE_RESET;
      // reset low at two rising edges: this one and the release edge
      @(posedge aclk);
      @(negedge aclk);
      chk_leg(16'h0, q);
      chk_leg(16'hFFFF, q_n);
      @(posedge aclk);
      aresetn <= 1'b1;
      rd(CTRL_OFS, ctrl_m);
      rd(GATE_OFS, gate_m);
      rd(4'hC, 32'h0);
      wr(4'hC, $random(seed));
      rd(CTRL_OFS, ctrl_m);
      // gated outputs at both disabled levels
      for (int dl = 0; dl < 2; dl++)
      begin
         wr(CTRL_OFS, 32'h8 | (dl << 2));
         wr(GATE_OFS, $random(seed));
         rd(GATE_OFS, gate_m);
         rd(CTRL_OFS, ctrl_m);
         repeat (3) @(negedge aclk);
         chk_leg((dl == 1) ? gate_m[15:0] : 16'h0, q & gate_m[15:0]);
         chk_leg((dl == 1) ? 16'h0 : gate_m[15:0], q_n & gate_m[15:0]);
      end
      wr(CTRL_OFS, 32'h8);
      wr(GATE_OFS, 32'h0);
      // ungating is not timed to the clock, so a runt may follow it
      repeat (20) @(posedge aclk);
      mon_on = 1'b1;
      settle(32'h0);
      // plain switch to the secondary
      wr(CTRL_OFS, 32'h9);
      settle(32'h1);
      // secondary dies: controller selects primary and forces
      mon_on = 1'b0;
      run_s  = 1'b0;
      repeat (50) @(posedge aclk);
      wr(CTRL_OFS, 32'hA);
      repeat (20) @(posedge aclk);
      mon_on = 1'b1;
      settle(32'h0);
      // held force ignores select and the dead input
      wr(CTRL_OFS, 32'hB);
      settle(32'h0);
      // revive, drop force, toggle select, raise force
      run_s = 1'b1;
      wr(CTRL_OFS, 32'h8);
      settle(32'h0);
      wr(CTRL_OFS, 32'h9);
      settle(32'h1);
      mon_on = 1'b0;
      wr(CTRL_OFS, 32'hB);
      // the forced park lands a few cycles after the write and may cut a pulse
      repeat (20) @(posedge aclk);
      mon_on = 1'b1;
      settle(32'h1);
      // disable outputs, then sleep
      mon_on = 1'b0;
      wr(GATE_OFS, 32'hFFFF);
      wr(CTRL_OFS, 32'h7);
      repeat (8) @(negedge aclk);
      chk_leg(16'hFFFF, q);
      chk_leg(16'hFFFF, q_n);
      axi_rd(STAT_OFS, got, rsp);
      chk_reg(32'h8, got & 32'h8);
      test_done();
   end
endmodule : gcs_switch_tb
